// ===== shared/nld_pkg.sv
// Constants and types of the per-phase no-load detector.
// Assumes one 40 MHz core clock and a simple internal register port from the serial interface.
package nld_pkg;

   localparam int NLD_DW = 16;
   localparam int NLD_AW = 3;
   localparam int NLD_PH = 3;
   localparam int NLD_NCNT = 4;

   // Register indices on the internal register port.
   localparam logic [2:0] NLD_ADDR_ACT_THR = 3'h0;
   localparam logic [2:0] NLD_ADDR_APP_THR = 3'h1;
   localparam logic [2:0] NLD_ADDR_REACT_THR = 3'h2;
   localparam logic [2:0] NLD_ADDR_PHASE_STATE = 3'h3;
   localparam logic [2:0] NLD_ADDR_STATUS = 3'h4;
   localparam logic [2:0] NLD_ADDR_MASK = 3'h5;

   // Status and mask bit positions.
   localparam int NLD_BIT_TOTAL = 0;
   localparam int NLD_BIT_FUND = 1;
   localparam int NLD_BIT_APP = 2;

   // Phase state field positions.
   localparam int NLD_PS_TOTAL_LSB = 0;
   localparam int NLD_PS_FUND_LSB = 3;
   localparam int NLD_PS_APP_LSB = 6;

   // Counter indices.
   localparam int NLD_C_TACT = 0;
   localparam int NLD_C_APP = 1;
   localparam int NLD_C_FACT = 2;
   localparam int NLD_C_FREACT = 3;

   localparam logic [15:0] NLD_THR_RST = 16'h0000;
   localparam logic [15:0] NLD_CNT_MAX = 16'hFFFF;
   localparam logic [2:0] NLD_FLAG_RST = 3'h0;

   // Detector time base: one tick per DSP energy update.
   localparam int NLD_CLK_HZ = 40000000;
   localparam int NLD_TICK_HZ = 8000;
   localparam int NLD_TICK_CYC = NLD_CLK_HZ / NLD_TICK_HZ;

   typedef struct packed {
      logic [2:0] tot_act;
      logic [2:0] app;
      logic [2:0] fund_act;
      logic [2:0] fund_react;
   } nld_lsb_s;

   typedef struct packed {
      logic [2:0] tot_act_en;
      logic [2:0] app_en;
      logic [2:0] fund_act_en;
      logic [2:0] fund_react_en;
   } nld_gate_s;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [2:0] addr;
      logic [15:0] wdata;
   } nld_req_s;

endpackage

// ===== design/nld_detector.sv
// Per-phase no-load detector with thresholds, phase state, status, mask and interrupt line.
// Assumes energy bit strobes are one-cycle pulses synchronous to clk, register port driven by the
// serial interface.
`timescale 1ns/1ps
module nld_detector #(
   parameter int TICK_DIV = nld_pkg::NLD_TICK_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire nld_pkg::nld_lsb_s lsb,
   input wire nld_pkg::nld_req_s req,
   output logic [15:0] reg_rdata,
   output nld_pkg::nld_gate_s gate,
   output logic interrupt_line_second_n
);
   import nld_pkg::*;

   typedef struct packed {
      logic [15:0] tick_cnt;
      logic [NLD_NCNT-1:0][NLD_PH-1:0][15:0] cnt;
      logic [NLD_NCNT-1:0][NLD_PH-1:0] expd;
      logic [15:0] active_no_load_threshold;
      logic [15:0] apparent_no_load_threshold;
      logic [15:0] reactive_no_load_threshold;
      logic [2:0] total_no_load_phase_bits;
      logic [2:0] fundamental_no_load_phase_bits;
      logic [2:0] apparent_no_load_phase_bits;
      logic [2:0] interrupt_status_second;
      logic [2:0] interrupt_mask_second;
      logic [15:0] rdata;
      nld_gate_s gate;
      logic irq_n;
   } nld_state_s;

   nld_state_s s_q;
   nld_state_s s_d;

   logic tick;
   logic [15:0] thr_of [NLD_NCNT];

   function automatic logic is_wr(input nld_req_s r, input logic [2:0] a);
      is_wr = r.sel && r.wr && (r.addr == a);
   endfunction

   assign tick = (s_q.tick_cnt == 16'(TICK_DIV - 1));

   // The fundamental active counter reuses the one active threshold.
   always_comb begin
      thr_of[NLD_C_TACT] = s_q.active_no_load_threshold;
      thr_of[NLD_C_APP] = s_q.apparent_no_load_threshold;
      thr_of[NLD_C_FACT] = s_q.active_no_load_threshold;
      thr_of[NLD_C_FREACT] = s_q.reactive_no_load_threshold;
   end

   always_comb begin
      logic [NLD_NCNT-1:0][NLD_PH-1:0] hit;
      logic act_z;
      logic app_z;
      logic rea_z;
      logic [2:0] clr;
      logic [2:0] set;
      hit = {lsb.fund_react, lsb.fund_act, lsb.app, lsb.tot_act};
      act_z = (s_q.active_no_load_threshold == NLD_THR_RST);
      app_z = (s_q.apparent_no_load_threshold == NLD_THR_RST);
      rea_z = (s_q.reactive_no_load_threshold == NLD_THR_RST);
      clr = 3'h0;
      set = 3'h0;
      s_d = s_q;
      s_d.tick_cnt = tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;

      // Each counter starts at the threshold and expires on the first tick that finds it at the top.
      for (int c = 0; c < NLD_NCNT; c++) begin
         for (int p = 0; p < NLD_PH; p++) begin
            if (hit[c][p]) begin
               s_d.cnt[c][p] = thr_of[c];
               s_d.expd[c][p] = 1'b0;
            end else if (tick && !s_q.expd[c][p]) begin
               if (s_q.cnt[c][p] == NLD_CNT_MAX) begin
                  s_d.expd[c][p] = 1'b1;
               end else begin
                  s_d.cnt[c][p] = s_q.cnt[c][p] + 16'h0001;
               end
            end
         end
      end

      for (int p = 0; p < NLD_PH; p++) begin
         // Total detector: both powers silent, or only the enabled one.
         if (act_z && app_z) begin
            s_d.total_no_load_phase_bits[p] = 1'b0;
         end else if (app_z) begin
            s_d.total_no_load_phase_bits[p] = s_d.expd[NLD_C_TACT][p];
         end else if (act_z) begin
            s_d.total_no_load_phase_bits[p] = s_d.expd[NLD_C_APP][p];
         end else begin
            s_d.total_no_load_phase_bits[p] = s_d.expd[NLD_C_TACT][p] && s_d.expd[NLD_C_APP][p];
         end
         // Fundamental detector: a zero threshold counts as always silent on that side.
         s_d.fundamental_no_load_phase_bits[p] = !(act_z && rea_z) &&
            (act_z || s_d.expd[NLD_C_FACT][p]) && (rea_z || s_d.expd[NLD_C_FREACT][p]);
         s_d.apparent_no_load_phase_bits[p] = !app_z && s_d.expd[NLD_C_APP][p];
      end

      s_d.gate.tot_act_en = ~s_d.total_no_load_phase_bits;
      s_d.gate.fund_act_en = act_z ? 3'h7 : ~s_d.fundamental_no_load_phase_bits;
      s_d.gate.fund_react_en = rea_z ? 3'h7 : ~s_d.fundamental_no_load_phase_bits;
      s_d.gate.app_en = ~s_d.apparent_no_load_phase_bits;

      // Any entry or exit sets the group flag, regardless of the mask; set beats clear.
      set[NLD_BIT_TOTAL] = s_d.total_no_load_phase_bits != s_q.total_no_load_phase_bits;
      set[NLD_BIT_FUND] = s_d.fundamental_no_load_phase_bits != s_q.fundamental_no_load_phase_bits;
      set[NLD_BIT_APP] = s_d.apparent_no_load_phase_bits != s_q.apparent_no_load_phase_bits;
      clr = is_wr(req, NLD_ADDR_STATUS) ? req.wdata[2:0] : 3'h0;
      s_d.interrupt_status_second = (s_q.interrupt_status_second & ~clr) | set;

      if (is_wr(req, NLD_ADDR_ACT_THR)) begin
         s_d.active_no_load_threshold = req.wdata;
      end
      if (is_wr(req, NLD_ADDR_APP_THR)) begin
         s_d.apparent_no_load_threshold = req.wdata;
      end
      if (is_wr(req, NLD_ADDR_REACT_THR)) begin
         s_d.reactive_no_load_threshold = req.wdata;
      end
      if (is_wr(req, NLD_ADDR_MASK)) begin
         s_d.interrupt_mask_second = req.wdata[2:0];
      end

      // Line low while any enabled flag stands.
      s_d.irq_n = ~|(s_d.interrupt_status_second & s_d.interrupt_mask_second);

      s_d.rdata = s_q.rdata;
      if (req.sel && !req.wr) begin
         case (req.addr)
            NLD_ADDR_ACT_THR: s_d.rdata = s_q.active_no_load_threshold;
            NLD_ADDR_APP_THR: s_d.rdata = s_q.apparent_no_load_threshold;
            NLD_ADDR_REACT_THR: s_d.rdata = s_q.reactive_no_load_threshold;
            NLD_ADDR_PHASE_STATE: s_d.rdata = {7'h00, s_q.apparent_no_load_phase_bits,
               s_q.fundamental_no_load_phase_bits, s_q.total_no_load_phase_bits};
            NLD_ADDR_STATUS: s_d.rdata = {13'h0000, s_q.interrupt_status_second};
            NLD_ADDR_MASK: s_d.rdata = {13'h0000, s_q.interrupt_mask_second};
            default: s_d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.gate <= '1;
         s_q.irq_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign gate = s_q.gate;
   assign interrupt_line_second_n = s_q.irq_n;

   property p_total_flag;
      @(posedge clk) disable iff (sys_rst)
      (s_q.total_no_load_phase_bits != $past(s_q.total_no_load_phase_bits)) |-> s_q.interrupt_status_second[0];
   endproperty
   a_total_flag: assert property (p_total_flag) else $error("total flag not set on state change");

   property p_fund_flag;
      @(posedge clk) disable iff (sys_rst)
      $changed(s_q.fundamental_no_load_phase_bits) |-> s_q.interrupt_status_second[1];
   endproperty
   a_fund_flag: assert property (p_fund_flag) else $error("fundamental flag not set on change");

   property p_app_flag;
      @(posedge clk) disable iff (sys_rst)
      $changed(s_q.apparent_no_load_phase_bits) |-> s_q.interrupt_status_second[2];
   endproperty
   a_app_flag: assert property (p_app_flag) else $error("apparent flag not set on change");

   property p_irq_low;
      @(posedge clk) disable iff (sys_rst)
      |(s_q.interrupt_status_second & s_q.interrupt_mask_second) |-> !interrupt_line_second_n;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("line high with enabled flag");

   property p_irq_masked;
      @(posedge clk) disable iff (sys_rst)
      (s_q.interrupt_mask_second == 3'h0) |-> interrupt_line_second_n;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("line low while all masked");

   property p_w1c;
      @(posedge clk) disable iff (sys_rst)
      (is_wr(req, NLD_ADDR_STATUS) && req.wdata[0] && !$changed(s_d.total_no_load_phase_bits)
         && (s_d.total_no_load_phase_bits == s_q.total_no_load_phase_bits)) |=> !s_q.interrupt_status_second[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("status bit 0 not cleared");

   property p_disabled;
      @(posedge clk) disable iff (sys_rst)
      (s_q.active_no_load_threshold == 16'h0000 && s_q.apparent_no_load_threshold == 16'h0000)
         |=> (s_q.total_no_load_phase_bits == 3'h0) || $changed(s_q.apparent_no_load_threshold)
         || $changed(s_q.active_no_load_threshold);
   endproperty
   a_disabled: assert property (p_disabled) else $error("total detector active while disabled");

   property p_lsb_restart;
      @(posedge clk) disable iff (sys_rst)
      (lsb.tot_act[0] && s_q.active_no_load_threshold != 16'h0000 && !is_wr(req, NLD_ADDR_ACT_THR))
         |=> !s_q.total_no_load_phase_bits[0] && s_q.gate.tot_act_en[0];
   endproperty
   a_lsb_restart: assert property (p_lsb_restart) else $error("total active bit did not leave no load");

   property p_app_off;
      @(posedge clk) disable iff (sys_rst)
      (s_q.apparent_no_load_threshold == 16'h0000) |=> s_q.apparent_no_load_phase_bits == 3'h0;
   endproperty
   a_app_off: assert property (p_app_off) else $error("apparent detector active while disabled");

   property p_fund_free;
      @(posedge clk) disable iff (sys_rst)
      (s_q.active_no_load_threshold == 16'h0000 && !is_wr(req, NLD_ADDR_ACT_THR)) |=> gate.fund_act_en == 3'h7;
   endproperty
   a_fund_free: assert property (p_fund_free) else $error("fundamental active blocked with zero threshold");

   property p_fund_react_free;
      @(posedge clk) disable iff (sys_rst)
      (s_q.reactive_no_load_threshold == 16'h0000) |=> s_q.gate.fund_react_en == 3'h7;
   endproperty
   a_fund_react_free: assert property (p_fund_react_free) else $error("reactive blocked with zero threshold");

   property p_fund_off;
      @(posedge clk) disable iff (sys_rst)
      (s_q.active_no_load_threshold == 16'h0000 && s_q.reactive_no_load_threshold == 16'h0000)
         |=> s_q.fundamental_no_load_phase_bits == 3'h0;
   endproperty
   a_fund_off: assert property (p_fund_off) else $error("fundamental detector active with both thresholds zero");

   property p_irq_high;
      @(posedge clk) disable iff (sys_rst)
      ((s_q.interrupt_status_second & s_q.interrupt_mask_second) == 3'h0) |-> interrupt_line_second_n;
   endproperty
   a_irq_high: assert property (p_irq_high) else $error("line low with no enabled flag");

   property p_status_sticky;
      @(posedge clk) disable iff (sys_rst)
      (s_q.interrupt_status_second[0] && !(is_wr(req, NLD_ADDR_STATUS) && req.wdata[0]))
         |=> s_q.interrupt_status_second[0];
   endproperty
   a_status_sticky: assert property (p_status_sticky) else $error("status bit 0 cleared without a write of one");

   property p_unmasked_flag;
      @(posedge clk) disable iff (sys_rst)
      ($changed(s_q.apparent_no_load_phase_bits) && s_q.interrupt_mask_second == 3'h0)
         |-> s_q.interrupt_status_second[2] && interrupt_line_second_n;
   endproperty
   a_unmasked_flag: assert property (p_unmasked_flag) else $error("masked flag not set or line pulled low");

   property p_fund_w1c;
      @(posedge clk) disable iff (sys_rst)
      (is_wr(req, NLD_ADDR_STATUS) && req.wdata[1]
         && (s_d.fundamental_no_load_phase_bits == s_q.fundamental_no_load_phase_bits))
         |=> !s_q.interrupt_status_second[1];
   endproperty
   a_fund_w1c: assert property (p_fund_w1c) else $error("status bit 1 not cleared");

   property p_app_w1c;
      @(posedge clk) disable iff (sys_rst)
      (is_wr(req, NLD_ADDR_STATUS) && req.wdata[2]
         && (s_d.apparent_no_load_phase_bits == s_q.apparent_no_load_phase_bits))
         |=> !s_q.interrupt_status_second[2];
   endproperty
   a_app_w1c: assert property (p_app_w1c) else $error("status bit 2 not cleared");

   // Read data reflects the register contents at the request edge and then stands.
   property p_rd_state;
      @(posedge clk) disable iff (sys_rst)
      (req.sel && !req.wr && req.addr == NLD_ADDR_PHASE_STATE) |=> reg_rdata == {7'h00,
         $past(s_q.apparent_no_load_phase_bits), $past(s_q.fundamental_no_load_phase_bits),
         $past(s_q.total_no_load_phase_bits)};
   endproperty
   a_rd_state: assert property (p_rd_state) else $error("phase state read wrong");

   property p_rd_status;
      @(posedge clk) disable iff (sys_rst)
      (req.sel && !req.wr && req.addr == NLD_ADDR_STATUS)
         |=> reg_rdata == {13'h0000, $past(s_q.interrupt_status_second)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");

   property p_rd_hold;
      @(posedge clk) disable iff (sys_rst)
      !(req.sel && !req.wr) |=> $stable(reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

   property p_mask_write;
      @(posedge clk) disable iff (sys_rst)
      is_wr(req, NLD_ADDR_MASK) |=> s_q.interrupt_mask_second == $past(req.wdata[2:0]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("mask write lost");

   property p_thr_write;
      @(posedge clk) disable iff (sys_rst)
      is_wr(req, NLD_ADDR_ACT_THR) |=> s_q.active_no_load_threshold == $past(req.wdata);
   endproperty
   a_thr_write: assert property (p_thr_write) else $error("active threshold write lost");

   // Restart, expiry and gating checks repeat for every phase.
   for (genvar gp = 0; gp < NLD_PH; gp++) begin : g_phase
      property p_app_restart;
         @(posedge clk) disable iff (sys_rst)
         (lsb.app[gp] && s_q.apparent_no_load_threshold != 16'h0000)
            |=> !s_q.apparent_no_load_phase_bits[gp] && s_q.gate.app_en[gp];
      endproperty
      a_app_restart: assert property (p_app_restart) else $error("apparent bit did not leave no load");

      property p_fund_restart;
         @(posedge clk) disable iff (sys_rst)
         (lsb.fund_act[gp] && s_q.active_no_load_threshold != 16'h0000)
            |=> !s_q.fundamental_no_load_phase_bits[gp] && s_q.gate.fund_act_en[gp];
      endproperty
      a_fund_restart: assert property (p_fund_restart) else $error("fundamental active bit ignored");

      property p_react_restart;
         @(posedge clk) disable iff (sys_rst)
         (lsb.fund_react[gp] && s_q.reactive_no_load_threshold != 16'h0000)
            |=> !s_q.fundamental_no_load_phase_bits[gp] && s_q.gate.fund_react_en[gp];
      endproperty
      a_react_restart: assert property (p_react_restart) else $error("fundamental reactive bit ignored");

      property p_total_expire;
         @(posedge clk) disable iff (sys_rst)
         (tick && s_q.cnt[NLD_C_TACT][gp] == NLD_CNT_MAX && !lsb.tot_act[gp]
            && s_q.active_no_load_threshold != 16'h0000 && s_q.apparent_no_load_threshold == 16'h0000)
            |=> s_q.total_no_load_phase_bits[gp] && !s_q.gate.tot_act_en[gp];
      endproperty
      a_total_expire: assert property (p_total_expire) else $error("active silence did not enter no load");

      property p_gate_follow;
         @(posedge clk) disable iff (sys_rst)
         s_q.gate.tot_act_en[gp] == !s_q.total_no_load_phase_bits[gp]
            && s_q.gate.app_en[gp] == !s_q.apparent_no_load_phase_bits[gp];
      endproperty
      a_gate_follow: assert property (p_gate_follow) else $error("gate does not follow phase state");
   end

   // Main scenarios: entry of each detector, the interrupt and a flag clear.
   c_total_enter: cover property (@(posedge clk) disable iff (sys_rst) $rose(s_q.total_no_load_phase_bits[0]));
   c_fund_enter: cover property (@(posedge clk) disable iff (sys_rst) $rose(s_q.fundamental_no_load_phase_bits[1]));
   c_irq: cover property (@(posedge clk) disable iff (sys_rst) $fell(interrupt_line_second_n));
   c_app_enter: cover property (@(posedge clk) disable iff (sys_rst) $rose(s_q.apparent_no_load_phase_bits[2]));
   c_status_clear: cover property (@(posedge clk) disable iff (sys_rst) $fell(s_q.interrupt_status_second[0]));

endmodule

// ===== tb/nld_energy_src.sv
// Energy pulse source that stands for the metering datapath ahead of the no-load detector.
// Assumes the bench sets the enable pattern; one pulse per enabled phase every eight clocks.
`timescale 1ns/1ps
module nld_energy_src (
   input wire logic clk,
   input wire logic sys_rst,
   input wire nld_pkg::nld_lsb_s en,
   output nld_pkg::nld_lsb_s lsb
);
   import nld_pkg::*;
   logic [2:0] cnt_q;
   // Pulses come every two detector ticks, so an enabled phase with a threshold below 16'hFFFE never expires.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 3'h0;
         lsb <= '0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
         lsb <= (cnt_q == 3'h0) ? en : '0;
      end
   end
endmodule

// ===== tb/tb_energy_no_load_detector.sv
// Self-checking bench of the no-load detector through its register port and energy strobes.
// Assumes the detector runs with TICK_DIV of 4 and the pulse source model beside it.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch %s %h %h", nm, e, a); end end
module tb_energy_no_load_detector;
   import nld_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   nld_req_s req = '0;
   nld_lsb_s en = '0;
   nld_lsb_s lsb;
   logic [15:0] reg_rdata;
   nld_gate_s gate;
   logic irq_n;
   int n_mismatch = 0;
   int tests_run = 0;
   nld_energy_src i_src (.clk(clk), .sys_rst(sys_rst), .en(en), .lsb(lsb));
   nld_detector #(.TICK_DIV(4)) i_dut (.clk(clk), .sys_rst(sys_rst), .lsb(lsb), .req(req),
      .reg_rdata(reg_rdata), .gate(gate), .interrupt_line_second_n(irq_n));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(negedge clk);
      req = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(negedge clk);
      req = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
      @(negedge clk);
      req = '0;
      `CHK("reg_rdata", e, reg_rdata)
   endtask
   // Loads every counter with its threshold, then leaves the given pattern running.
   task automatic kick(input nld_lsb_s keep);
      en = '1;
      repeat (20) @(negedge clk);
      en = keep;
   endtask
   task automatic settle(input nld_gate_s e);
      int i;
      i = 0;
      while (gate !== e && i < 400) begin
         @(negedge clk);
         i++;
      end
      `CHK("gate", e, gate)
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      n_mismatch++;
      summarize();
   end
   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      `CHK("gate", 12'hFFF, gate)
      `CHK("irq", 1'b1, irq_n)
      for (int a = 0; a < 7; a++) rd(a[2:0], 16'h0000);
      $display("test reset done");
      for (int a = 0; a < 3; a++) begin
         wr(a[2:0], 16'h1234 + a);
         rd(a[2:0], 16'h1234 + a);
      end
      wr(NLD_ADDR_PHASE_STATE, 16'hFFFF);
      rd(NLD_ADDR_PHASE_STATE, 16'h0000);
      wr(3'h6, 16'hFFFF);
      rd(3'h6, 16'h0000);
      $display("test access done");
      for (int a = 0; a < 3; a++) wr(a[2:0], 16'h0000);
      wr(NLD_ADDR_MASK, 16'h0007);
      kick('0);
      repeat (300) @(negedge clk);
      `CHK("gate", 12'hFFF, gate)
      rd(NLD_ADDR_STATUS, 16'h0000);
      `CHK("irq", 1'b1, irq_n)
      $display("test disabled done");
      for (int a = 0; a < 3; a++) wr(a[2:0], 16'hFFF0);
      kick('0);
      settle(12'h000);
      rd(NLD_ADDR_STATUS, 16'h0007);
      rd(NLD_ADDR_PHASE_STATE, 16'h01FF);
      `CHK("irq", 1'b0, irq_n)
      wr(NLD_ADDR_STATUS, 16'h0001);
      `CHK("irq", 1'b0, irq_n)
      rd(NLD_ADDR_STATUS, 16'h0006);
      wr(NLD_ADDR_STATUS, 16'h0006);
      `CHK("irq", 1'b1, irq_n)
      rd(NLD_ADDR_STATUS, 16'h0000);
      $display("test entry done");
      wr(NLD_ADDR_MASK, 16'h0000);
      en = 12'h249;
      settle(12'h249);
      rd(NLD_ADDR_STATUS, 16'h0007);
      rd(NLD_ADDR_PHASE_STATE, 16'h01B6);
      `CHK("irq", 1'b1, irq_n)
      $display("test exit done");
      en = '0;
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      `CHK("gate", 12'hFFF, gate)
      rd(NLD_ADDR_STATUS, 16'h0000);
      wr(NLD_ADDR_ACT_THR, 16'hFFF0);
      wr(NLD_ADDR_MASK, 16'h0007);
      kick(12'h1C0);
      settle(12'h1C7);
      rd(NLD_ADDR_PHASE_STATE, 16'h003F);
      rd(NLD_ADDR_STATUS, 16'h0003);
      `CHK("irq", 1'b0, irq_n)
      $display("test single threshold done");
      wr(NLD_ADDR_STATUS, 16'h0003);
      `CHK("irq", 1'b1, irq_n)
      wr(NLD_ADDR_ACT_THR, 16'h0000);
      settle(12'hFFF);
      rd(NLD_ADDR_STATUS, 16'h0003);
      rd(NLD_ADDR_PHASE_STATE, 16'h0000);
      `CHK("irq", 1'b0, irq_n)
      $display("test late disable done");
      summarize();
   end
endmodule
